// [vbatr_regs.sv]
// vbus alarm, discharge stop and output target register group
// Functional notes
// RQ1: discharge stop level upper bits join lower byte
// RQ2: over-voltage level ten bits at 0x76/0x77
// RQ3: under-voltage level ten bits at 0x78/0x79
// RQ4: alarm disable bit zero enables alarms
// RQ5: output above over level sets flag
// RQ6: output below under level sets flag
// RQ7: over flag re-sets while condition persists
// RQ8: under flag re-sets while condition persists
// RQ9: target applies on non-default source command
// RQ10: coarse mode ten bits, codes 0x00a5-0x03ff
// RQ11: fine mode eleven bits, codes 0x014a-0x07ff
// RQ12: host keeps target code within valid range
// RQ13: host computes fine code with integer formula
// RQ14: stop level drops two bits, floor 0.5 V
// RQ15: compare measurement on each new conversion
`timescale 1ns/10ps
`default_nettype none
module vbatr_regs (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // register access from the port manager side
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_hit_o,
  // control and flag handling
  input wire logic voltage_alarm_disable_i,
  input wire logic over_flag_clr_i,
  input wire logic under_flag_clr_i,
  output logic over_voltage_alarm_flag_o,
  output logic under_voltage_alarm_flag_o,
  // measurement and regulation
  input wire logic [9:0] vout_meas_i,
  input wire logic meas_valid_i,
  input wire logic fine_resolution_select_i,
  input wire logic nondefault_cmd_i,
  output logic [9:0] discharge_stop_level_o,
  output logic [10:0] active_target_o,
  output logic target_range_err_o
);
  logic [63:0] words;
  logic [7:0] rf_rdata;
  logic rd_pend;
  logic in_map;
  logic [2:0] idx;
  logic [9:0] dstop_raw;
  logic [9:0] over_trip;
  logic [9:0] under_trip;
  logic [15:0] tgt_raw;
  logic [9:0] meas_hold;
  logic over_cond;
  logic under_cond;
  logic tgt_ok;
  logic [9:0] dstop_masked;
  logic [9:0] next_dstop;
  logic [10:0] next_target;
  logic upper_sel;
  logic [7:0] rf_wdata;

  assign in_map = reg_addr_i >= vbatr_pkg::ADDR_DSTOP_LOWER
               && reg_addr_i <= vbatr_pkg::ADDR_TGT_UPPER;
  assign idx = 3'(reg_addr_i - vbatr_pkg::ADDR_DSTOP_LOWER);
  // upper level bytes keep bits 1:0 only, so the reserved bits always read back as zero
  assign upper_sel = idx[0] && (idx != 3'd7); // [RQ1] [RQ2] [RQ3]
  assign rf_wdata = upper_sel ? {6'h00, reg_wdata_i[1:0]} : reg_wdata_i; // [RQ1] [RQ2] [RQ3]

  vbatr_regfile #(.DEPTH(8)) u_rf (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .wr_en_i(reg_wr_i && in_map),
    .wr_idx_i(idx),
    .wr_data_i(rf_wdata),
    .rd_idx_i(idx),
    .rd_data_o(rf_rdata),
    .words_o(words)
  );

  // upper level registers keep only bits 1:0, the rest read as zero
  assign dstop_raw = {words[8 +: 2], words[0 +: 8]}; // [RQ1]
  assign over_trip = {words[24 +: 2], words[16 +: 8]}; // [RQ2]
  assign under_trip = {words[40 +: 2], words[32 +: 8]}; // [RQ3]
  assign tgt_raw = {words[56 +: 8], words[48 +: 8]}; // [RQ9]

  // bits 1:0 ignored; codes at or below the floor code mean 0.5 V
  assign dstop_masked = dstop_raw & vbatr_pkg::DSTOP_LSB_MASK; // [RQ14]
  assign next_dstop = (dstop_masked <= vbatr_pkg::DSTOP_FLOOR_CODE)
                    ? vbatr_pkg::DSTOP_FLOOR_VAL : dstop_masked; // [RQ14]

  // the measurement is held until a new conversion, so a flag cannot chatter between results
  assign over_cond = !voltage_alarm_disable_i && meas_hold > over_trip; // [RQ4] [RQ5]
  assign under_cond = !voltage_alarm_disable_i && meas_hold < under_trip; // [RQ4] [RQ6]

  assign tgt_ok = fine_resolution_select_i
    ? (tgt_raw >= vbatr_pkg::TGT_FINE_MIN && tgt_raw <= vbatr_pkg::TGT_FINE_MAX) // [RQ11]
    : (tgt_raw >= vbatr_pkg::TGT_COARSE_MIN && tgt_raw <= vbatr_pkg::TGT_COARSE_MAX); // [RQ10]
  // coarse codes are doubled so the regulator always sees the fine scale
  assign next_target = fine_resolution_select_i ? tgt_raw[10:0]
                     : {tgt_raw[9:0], 1'b0}; // [RQ10] [RQ11]

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      meas_hold <= 10'h000;
    end else if (meas_valid_i) begin
      meas_hold <= vout_meas_i; // [RQ15]
    end
  end

  // set wins over a clear in the same cycle, which gives the re-assert
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      over_voltage_alarm_flag_o <= 1'b0;
    end else if (over_cond) begin
      over_voltage_alarm_flag_o <= 1'b1; // [RQ5] [RQ7]
    end else if (over_flag_clr_i) begin
      over_voltage_alarm_flag_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      under_voltage_alarm_flag_o <= 1'b0;
    end else if (under_cond) begin
      under_voltage_alarm_flag_o <= 1'b1; // [RQ6] [RQ8]
    end else if (under_flag_clr_i) begin
      under_voltage_alarm_flag_o <= 1'b0;
    end
  end

  // the written target is only latched when the source command arrives
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      active_target_o <= 11'h000;
      target_range_err_o <= 1'b0;
    end else if (nondefault_cmd_i) begin
      active_target_o <= next_target; // [RQ9]
      target_range_err_o <= !tgt_ok; // [RQ12]
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      discharge_stop_level_o <= vbatr_pkg::DSTOP_FLOOR_VAL;
      rd_pend <= 1'b0;
      reg_hit_o <= 1'b0;
    end else begin
      discharge_stop_level_o <= next_dstop;
      rd_pend <= reg_rd_i && in_map;
      reg_hit_o <= (reg_rd_i || reg_wr_i) && in_map;
    end
  end

  // unmapped reads return zero
  assign reg_rdata_o = rd_pend ? rf_rdata : 8'h00;

  AST_OVER_SET: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    over_cond |=> over_voltage_alarm_flag_o) // [RQ7]
    else $error("over flag not set");
  AST_UNDER_SET: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    under_cond |=> under_voltage_alarm_flag_o) // [RQ8]
    else $error("under flag not set");
  AST_OVER_DIS: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    voltage_alarm_disable_i && over_flag_clr_i |=> !over_voltage_alarm_flag_o) // [RQ4]
    else $error("over flag set while disabled");
  AST_UNDER_RISE: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $rose(under_voltage_alarm_flag_o) |-> $past(under_cond)) // [RQ6]
    else $error("under flag rose without cause");
  AST_OVER_RISE: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $rose(over_voltage_alarm_flag_o) |-> $past(meas_hold) > $past(over_trip)) // [RQ5]
    else $error("over flag rose without cause");
  AST_TGT_HOLD: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !nondefault_cmd_i |=> $stable(active_target_o)) // [RQ9]
    else $error("target moved without command");
  AST_TGT_FINE: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    nondefault_cmd_i && fine_resolution_select_i |=> active_target_o == $past(tgt_raw[10:0])) // [RQ11]
    else $error("fine target wrong");
  AST_TGT_COARSE: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    nondefault_cmd_i && !fine_resolution_select_i
    |=> active_target_o == {$past(tgt_raw[9:0]), 1'b0}) // [RQ10]
    else $error("coarse target wrong");
  AST_DSTOP_FLOOR: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    discharge_stop_level_o[1:0] == 2'b00
    && discharge_stop_level_o >= vbatr_pkg::DSTOP_FLOOR_VAL) // [RQ14]
    else $error("stop level out of form");
  AST_UPPER_BITS: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    rd_pend && $past(reg_addr_i) == vbatr_pkg::ADDR_OVT_UPPER
    |-> reg_rdata_o == {6'h00, over_trip[9:8]} || $past(reg_wr_i)) // [RQ2]
    else $error("upper read mismatch");
endmodule
`default_nettype wire

// [vbatr_pkg.sv]
// package: register map, reset values and field layout of the vbus alarm and target registers
package vbatr_pkg;
  localparam logic [7:0] ADDR_DSTOP_LOWER = 8'h74;
  localparam logic [7:0] ADDR_DSTOP_UPPER = 8'h75;
  localparam logic [7:0] ADDR_OVT_LOWER = 8'h76;
  localparam logic [7:0] ADDR_OVT_UPPER = 8'h77;
  localparam logic [7:0] ADDR_UVT_LOWER = 8'h78;
  localparam logic [7:0] ADDR_UVT_UPPER = 8'h79;
  localparam logic [7:0] ADDR_TGT_LOWER = 8'h7a;
  localparam logic [7:0] ADDR_TGT_UPPER = 8'h7b;
  localparam logic [7:0] RST_DSTOP_LOWER = 8'h20;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam int UPPER_MSB = 1;
  localparam int LVL_W = 10;
  localparam int TGT_W = 16;
  localparam logic [9:0] DSTOP_FLOOR_CODE = 10'h018;
  localparam logic [9:0] DSTOP_FLOOR_VAL = 10'h014;
  localparam logic [9:0] DSTOP_LSB_MASK = 10'h3fc;
  localparam logic [15:0] TGT_COARSE_MIN = 16'h00a5;
  localparam logic [15:0] TGT_COARSE_MAX = 16'h03ff;
  localparam logic [15:0] TGT_FINE_MIN = 16'h014a;
  localparam logic [15:0] TGT_FINE_MAX = 16'h07ff;
endpackage

// [vbatr_regfile.sv]
// small memory of eight byte registers with registered read data
`timescale 1ns/10ps
`default_nettype none
module vbatr_regfile #(
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // write port
  input wire logic wr_en_i,
  input wire logic [2:0] wr_idx_i,
  input wire logic [7:0] wr_data_i,
  // read port
  input wire logic [2:0] rd_idx_i,
  output logic [7:0] rd_data_o,
  // all words, flat, for the comparators
  output logic [DEPTH*8-1:0] words_o
);
  logic [7:0] mem [DEPTH];
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_word
      always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
          mem[g] <= (g == 0) ? vbatr_pkg::RST_DSTOP_LOWER : vbatr_pkg::RST_ZERO;
        end else if (wr_en_i && wr_idx_i == 3'(g)) begin
          mem[g] <= wr_data_i;
        end
      end
      assign words_o[g*8 +: 8] = mem[g];
    end
  endgenerate
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rd_data_o <= 8'h00;
    end else begin
      rd_data_o <= mem[rd_idx_i];
    end
  end
endmodule
`default_nettype wire

// [vbatr_host_model.sv]
// port manager host model: fine-resolution target code from a millivolt request
`timescale 1ns/10ps
`default_nettype none
module vbatr_host_model (
  // request
  input wire logic [15:0] mv_i,
  // code to write
  output logic [15:0] code_o
);
  wire [31:0] mv = {16'h0000, mv_i};
  wire [31:0] raw = mv / 32'd10 - ((mv * 32'd304) / 32'd100000 - 32'd10);
  // clamp, so a wild request can never reach the target registers
  assign code_o = (raw < 32'h14a) ? 16'h014a : (raw > 32'h7ff) ? 16'h07ff : raw[15:0];
endmodule
`default_nettype wire

// [test_vbatr_regs.sv]
// self-checking bench for the vbus alarm and target registers
`timescale 1ns/10ps
`default_nettype none
module test_vbatr_regs;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic wr = 1'b0, rd = 1'b0, dis = 1'b0, oclr = 1'b0, uclr = 1'b0;
  logic mv = 1'b0, fine = 1'b0, cmd = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00;
  logic [9:0] meas = 10'h000;
  logic [7:0] rdata;
  logic hit, ovf, uvf, rerr;
  logic [9:0] dstop;
  logic [10:0] tgt;
  logic [15:0] code;
  int bad_count = 0;
  int cmp_count = 0;
  vbatr_regs dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_hit_o(hit),
    .voltage_alarm_disable_i(dis), .over_flag_clr_i(oclr), .under_flag_clr_i(uclr),
    .over_voltage_alarm_flag_o(ovf), .under_voltage_alarm_flag_o(uvf), .vout_meas_i(meas),
    .meas_valid_i(mv), .fine_resolution_select_i(fine), .nondefault_cmd_i(cmd),
    .discharge_stop_level_o(dstop), .active_target_o(tgt), .target_range_err_o(rerr));
  vbatr_host_model host (.mv_i(16'd5000), .code_o(code));
  initial begin
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk_sys_i);
    wr = 1'b0;
    @(negedge clk_sys_i);
  endtask
  // read data and hit stand for one cycle only, so look at them at once
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    rd = 1'b1;
    @(negedge clk_sys_i);
    rd = 1'b0;
    check({8'h00, rdata}, {8'h00, exp});
    check({15'h0, hit}, {15'h0, (a >= vbatr_pkg::ADDR_DSTOP_LOWER && a <= vbatr_pkg::ADDR_TGT_UPPER)});
    @(negedge clk_sys_i);
  endtask
  task automatic pulse(input logic m, input logic o, input logic u, input logic c);
    mv = m;
    oclr = o;
    uclr = u;
    cmd = c;
    @(negedge clk_sys_i);
    {mv, oclr, uclr, cmd} = 4'h0;
    repeat (2) @(negedge clk_sys_i);
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    for (int i = 0; i < 8; i++) rd_reg(8'h74 + i[7:0], (i == 0) ? vbatr_pkg::RST_DSTOP_LOWER : 8'h00);
    rd_reg(8'h80, 8'h00);
    wr_reg(8'h75, 8'h01);
    wr_reg(8'h74, 8'h21);
    check({6'h0, dstop}, 16'h0120);
    wr_reg(8'h75, 8'h00);
    wr_reg(8'h74, 8'h18);
    check({6'h0, dstop}, 16'h0014);
    wr_reg(8'h80, 8'h55);
    wr_reg(8'h76, 8'h90);
    wr_reg(8'h77, 8'hfd);
    wr_reg(8'h78, 8'h50);
    rd_reg(8'h77, 8'h01);
    rd_reg(8'h78, 8'h50);
    meas = 10'h190;
    pulse(1'b1, 1'b0, 1'b0, 1'b0);
    check({15'h0, ovf}, 16'h0000);
    meas = 10'h191;
    pulse(1'b1, 1'b0, 1'b0, 1'b0);
    check({15'h0, ovf}, 16'h0001);
    pulse(1'b0, 1'b1, 1'b0, 1'b0);
    check({15'h0, ovf}, 16'h0001);
    dis = 1'b1;
    pulse(1'b0, 1'b1, 1'b0, 1'b0);
    check({15'h0, ovf}, 16'h0000);
    dis = 1'b0;
    meas = 10'h050;
    pulse(1'b1, 1'b0, 1'b1, 1'b0);
    check({15'h0, uvf}, 16'h0000);
    meas = 10'h04f;
    pulse(1'b1, 1'b0, 1'b0, 1'b0);
    check({15'h0, uvf}, 16'h0001);
    pulse(1'b0, 1'b0, 1'b1, 1'b0);
    check({15'h0, uvf}, 16'h0001);
    dis = 1'b1;
    pulse(1'b0, 1'b0, 1'b1, 1'b0);
    check({15'h0, uvf}, 16'h0000);
    fine = 1'b1;
    wr_reg(8'h7a, code[7:0]);
    wr_reg(8'h7b, code[15:8]);
    check({5'h0, tgt}, 16'h0000);
    pulse(1'b0, 1'b0, 1'b0, 1'b1);
    check({5'h0, tgt}, 16'h01ef);
    check({15'h0, rerr}, 16'h0000);
    fine = 1'b0;
    wr_reg(8'h7a, 8'ha5);
    wr_reg(8'h7b, 8'h00);
    pulse(1'b0, 1'b0, 1'b0, 1'b1);
    check({5'h0, tgt}, 16'h014a);
    check({15'h0, rerr}, 16'h0000);
    wr_reg(8'h7a, 8'ha4);
    pulse(1'b0, 1'b0, 1'b0, 1'b1);
    check({15'h0, rerr}, 16'h0001);
    finish_test();
  end
  // the whole sequence needs well under 200 cycles
  initial begin
    #20000;
    bad_count++;
    finish_test();
  end
endmodule
`default_nettype wire
